// [rtl/adcspi_pkg.sv]
// constants and types shared by the converter serial interface
// Function
// R1: async mode: chip select low spans frame
// R2: chip select high resets link, floats output
// R3: async mode: ready falls on every conversion
// R4: accept continuous or byte-grouped clock bursts
// R5: host keeps serial clock low when idle
// R6: sample data input on falling clock edge
// R7: apply command only after frame completes
// R8: update data output on rising clock edge
// R9: float data output after final bit
// R10: ready low in frame, high on select rise
// R11: overrun pulses ready high half modulator period
// R12: overrun sets missed flag, keeps old data
// R13: ready pin driven in async and master modes, floated in slave mode
// R14: master mode: device drives clock, ready, data
// R15: master mode: continuous clock, frame at ready fall
// R16: master mode: ready fall loads output shifter
// R17: master mode: ready rises after last bit
// R18: host sets internal clock fast enough
// R19: master mode: host changes input on rising
// R20: slave mode: host drives select, clock, ready
// R21: slave mode: controller keeps exact clock timing
// R22: slave mode: select frames each transfer
// R23: latch three-level mode pin after reset
// R24: clock polarity zero, phase one only
// R25: slave mode: unexpected ready fall flags resync
// R26: count clock edges using word size, words
package adcspi_pkg;

  // ----------------------------------------------------------------
  // frame shape
  // ----------------------------------------------------------------
  localparam int WORD_BITS_DEF   = 24;
  localparam int FRAME_WORDS_DEF = 6;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int MOD_PERIOD_NS   = 1000;
  localparam int HALF_MOD_CYC    = (MOD_PERIOD_NS * 1000 / 2) / CLK_PERIOD_PS < 1 ? 1 :
                                   (MOD_PERIOD_NS * 1000 / 2) / CLK_PERIOD_PS;
  localparam int INTERNAL_CLOCK_HALF_DEF   = 4;
  localparam int SYNC_WIN_DEF    = 8;
  localparam int MODE_LATCH_WAIT = 3;

  // ----------------------------------------------------------------
  // modes and ready states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    AM_ASYNC  = 3'b001,
    AM_MASTER = 3'b010,
    AM_SLAVE  = 3'b100
  } adcspi_mode_t;

  typedef enum logic [2:0] {
    RS_HIGH  = 3'b001,
    RS_LOW   = 3'b010,
    RS_PULSE = 3'b100
  } adcspi_rdy_t;

endpackage

// [rtl/adcspi_frame_if.sv]
// frame carrier between the shift engines and the core
`timescale 1ns/1ps
`default_nettype none
interface adcspi_frame_if #(
  parameter int FB = 144,
  parameter int WB = 24
);
  logic [FB-1:0] tx_word;
  logic          start;
  logic [WB-1:0] rx_word;
  logic          done_tgl;
  logic          active;

  modport eng  (input tx_word, input start, output rx_word, output done_tgl, output active);
  modport core (output tx_word, output start, input rx_word, input done_tgl, input active);
endinterface
`default_nettype wire

// [rtl/adcspi_link.sv]
// shift engine on the host-driven serial clock (async and slave modes)
`timescale 1ns/1ps
`default_nettype none
module adcspi_link
  import adcspi_pkg::*;
#(
  parameter int FB = 144,
  parameter int WB = 24
) (
  // link clock and resets
  input  wire logic    sclk_in,
  input  wire logic    rst_in,
  input  wire logic    frame_rst_in,
  // pins
  input  wire logic    din_in,
  output logic         dout_out,
  output logic         dout_oe_out,
  // core side
  adcspi_frame_if.eng  frm
);
  localparam int CW = $clog2(FB + 1);

  logic [CW-1:0] tx_cnt_reg;
  logic [CW-1:0] rx_cnt_reg;
  logic [FB-1:0] tx_sh_reg;
  logic [WB-1:0] rx_sh_reg;
  logic [WB-1:0] cmd_reg;
  logic          dout_reg;
  logic          done_reg;
  logic          tgl_reg;

  wire tx_first = (tx_cnt_reg == '0);
  wire tx_more  = (tx_cnt_reg != CW'(FB));
  wire rx_last  = (rx_cnt_reg == CW'(FB - 1));

  // ----------------------------------------------------------------
  // output side: rising edges, select high clears the frame
  // ----------------------------------------------------------------
  always_ff @(posedge sclk_in or posedge frame_rst_in) begin // R2
    if (frame_rst_in) begin
      tx_cnt_reg <= '0;
      tx_sh_reg  <= '0;
      dout_reg   <= 1'b0;
    end else if (tx_more) begin // R26
      tx_cnt_reg <= tx_cnt_reg + CW'(1);
      dout_reg   <= tx_first ? frm.tx_word[FB-1] : tx_sh_reg[FB-1]; // R8
      tx_sh_reg  <= tx_first ? {frm.tx_word[FB-2:0], 1'b0} : {tx_sh_reg[FB-2:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // input side: falling edges; bursts may pause anywhere
  // ----------------------------------------------------------------
  always_ff @(negedge sclk_in or posedge frame_rst_in) begin // R4
    if (frame_rst_in) begin
      rx_cnt_reg <= '0;
      rx_sh_reg  <= '0;
      done_reg   <= 1'b0;
    end else if (!done_reg) begin
      rx_cnt_reg <= rx_cnt_reg + CW'(1);
      if (rx_cnt_reg < CW'(WB)) begin
        rx_sh_reg <= {rx_sh_reg[WB-2:0], din_in}; // R6
      end
      if (rx_last) begin
        done_reg <= 1'b1; // R9
      end
    end
  end

  // survives select: the core picks the word up after the toggle
  always_ff @(negedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      cmd_reg <= '0;
      tgl_reg <= 1'b0;
    end else if (!frame_rst_in && !done_reg && rx_last) begin // R7
      cmd_reg <= rx_sh_reg;
      tgl_reg <= ~tgl_reg;
    end
  end

  assign dout_out     = dout_reg;
  assign dout_oe_out  = !tx_first && !done_reg && !frame_rst_in; // R2 R9
  assign frm.rx_word  = cmd_reg;
  assign frm.done_tgl = tgl_reg;
  assign frm.active   = !tx_first && !done_reg;
endmodule
`default_nettype wire

// [rtl/adcspi_master.sv]
// shift engine that makes the serial clock itself (master mode)
`timescale 1ns/1ps
`default_nettype none
module adcspi_master
  import adcspi_pkg::*;
#(
  parameter int FB   = 144,
  parameter int WB   = 24,
  parameter int HALF = INTERNAL_CLOCK_HALF_DEF
) (
  input  wire logic    clk_in,
  input  wire logic    rst_in,
  input  wire logic    din_in,
  output logic         sclk_out,
  output logic         dout_out,
  output logic         dout_oe_out,
  adcspi_frame_if.eng  frm
);
  localparam int CW = $clog2(FB + 1);
  localparam int DW = $clog2(HALF + 1);

  logic [DW-1:0] div_reg;
  logic          sclk_reg;
  logic          active_reg;
  logic [CW-1:0] tx_cnt_reg;
  logic [CW-1:0] rx_cnt_reg;
  logic [FB-1:0] tx_sh_reg;
  logic [WB-1:0] rx_sh_reg;
  logic [WB-1:0] cmd_reg;
  logic          dout_reg;
  logic          tgl_reg;
  logic          pend_reg;

  wire tick = (div_reg == DW'(HALF - 1));
  // a start that meets a clock edge waits a cycle, so ready never falls on a clock edge
  wire go   = (frm.start || pend_reg) && !tick;
  wire rise = tick && !sclk_reg;
  wire fall = tick && sclk_reg;
  wire rx_ok = active_reg && fall && (rx_cnt_reg < tx_cnt_reg);

  // ----------------------------------------------------------------
  // free-running internal clock onto the pin
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin // R15
    if (rst_in) begin
      div_reg  <= '0;
      sclk_reg <= 1'b0;
      pend_reg <= 1'b0;
    end else begin
      div_reg  <= tick ? '0 : div_reg + DW'(1);
      sclk_reg <= sclk_reg ^ tick;
      pend_reg <= (frm.start || pend_reg) && tick;
    end
  end

  // ----------------------------------------------------------------
  // frame: load at start, shift on rising, sample on falling
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      active_reg <= 1'b0;
      tx_cnt_reg <= '0;
      rx_cnt_reg <= '0;
      tx_sh_reg  <= '0;
      rx_sh_reg  <= '0;
      cmd_reg    <= '0;
      dout_reg   <= 1'b0;
      tgl_reg    <= 1'b0;
    end else if (go) begin // R16
      active_reg <= 1'b1;
      tx_cnt_reg <= '0;
      rx_cnt_reg <= '0;
      tx_sh_reg  <= frm.tx_word;
    end else begin
      if (active_reg && rise && tx_cnt_reg != CW'(FB)) begin // R8
        dout_reg   <= tx_sh_reg[FB-1];
        tx_sh_reg  <= {tx_sh_reg[FB-2:0], 1'b0};
        tx_cnt_reg <= tx_cnt_reg + CW'(1);
      end
      if (rx_ok) begin // R6 R26
        rx_cnt_reg <= rx_cnt_reg + CW'(1);
        if (rx_cnt_reg < CW'(WB)) begin
          rx_sh_reg <= {rx_sh_reg[WB-2:0], din_in};
        end
        if (rx_cnt_reg == CW'(FB - 1)) begin
          active_reg <= 1'b0; // R17
          cmd_reg    <= rx_sh_reg;
          tgl_reg    <= ~tgl_reg;
        end
      end
    end
  end

  assign sclk_out     = sclk_reg;
  assign dout_out     = dout_reg;
  assign dout_oe_out  = active_reg && (tx_cnt_reg != '0); // R9
  assign frm.rx_word  = cmd_reg;
  assign frm.done_tgl = tgl_reg;
  assign frm.active   = active_reg;
endmodule
`default_nettype wire

// [rtl/adcspi_top.sv]
// converter serial interface: mode latch, ready logic, result hand-off
`timescale 1ns/1ps
`default_nettype none
module adcspi_top
  import adcspi_pkg::*;
#(
  parameter int WORD_BITS   = WORD_BITS_DEF,
  parameter int FRAME_WORDS = FRAME_WORDS_DEF,
  parameter int HALF_MOD    = HALF_MOD_CYC,
  parameter int INTERNAL_CLOCK_HALF   = INTERNAL_CLOCK_HALF_DEF,
  parameter int SYNC_WIN    = SYNC_WIN_DEF
) (
  // system clock and reset
  input  wire logic                             CLK_IN,
  input  wire logic                             RST_IN,
  // serial link
  input  wire logic                             SCLK_IN,
  output logic                                  SCLK_OUT,
  output logic                                  SCLK_OE_OUT,
  input  wire logic                             CS_N_IN,
  input  wire logic                             DIN_IN,
  output logic                                  DOUT_OUT,
  output logic                                  DOUT_OE_OUT,
  // ready pin
  input  wire logic                             CONVERSION_READY_N_IN,
  output logic                                  CONVERSION_READY_N_OUT,
  output logic                                  CONVERSION_READY_N_OE_OUT,
  // three-level mode pin, seen as two comparators
  input  wire logic                             MODE_PIN_HIGH_IN,
  input  wire logic                             MODE_PIN_LOW_IN,
  // converter side
  input  wire logic                             CONV_DONE_IN,
  input  wire logic [WORD_BITS*FRAME_WORDS-1:0] RESULT_IN,
  output logic                                  FILTER_RESET_OUT,
  // commands and status
  output logic [WORD_BITS-1:0]                  CMD_WORD_OUT,
  output logic                                  CMD_VALID_OUT,
  output logic                                  MISSED_RESULT_FLAG_OUT,
  output logic                                  RESYNC_EVENT_FLAG_OUT,
  input  wire logic                             FLAG_CLEAR_IN,
  output logic [2:0]                            MODE_OUT
);
  localparam int FB = WORD_BITS * FRAME_WORDS;
  localparam int HW = $clog2(HALF_MOD + 1);
  localparam int SW = $clog2(SYNC_WIN + 1);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (WORD_BITS < 2 || FRAME_WORDS < 2) begin : g_bad_frame
    $error("frame needs at least two words of two bits");
  end
  if (INTERNAL_CLOCK_HALF < 4) begin : g_bad_internal_clock
    $error("internal clock half period must cover the input synchroniser");
  end
  if (HALF_MOD < 1 || SYNC_WIN < 1) begin : g_bad_count
    $error("counts must be at least one");
  end

  // ----------------------------------------------------------------
  // pin synchronisers: first stage feeds only the second
  // ----------------------------------------------------------------
  localparam int NS = 7;
  logic [NS-1:0] sync1_reg;
  logic [NS-1:0] sync2_reg;
  logic [NS-1:0] prev_reg;

  wire [NS-1:0] async_pins = {CS_N_IN, CONVERSION_READY_N_IN, MODE_PIN_HIGH_IN,
                              MODE_PIN_LOW_IN, DIN_IN, 1'b0, 1'b0};
  wire          link_act_raw;
  wire          link_tgl_raw;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      // engine bits reset to their idle zero: no false done edge after reset
      sync1_reg <= 7'h7c;
      sync2_reg <= 7'h7c;
      prev_reg  <= 7'h7c;
    end else begin
      sync1_reg <= async_pins | {5'h00, link_act_raw, link_tgl_raw};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  wire cs_n_s     = sync2_reg[6];
  wire rdy_in_s   = sync2_reg[5];
  wire pin_high_s = sync2_reg[4];
  wire pin_low_s  = sync2_reg[3];
  wire din_s      = sync2_reg[2];
  wire link_act_s = sync2_reg[1];
  wire cs_rise    = cs_n_s && !prev_reg[6];
  wire rdy_fall   = !rdy_in_s && prev_reg[5];
  wire link_done  = sync2_reg[0] ^ prev_reg[0];

  // ----------------------------------------------------------------
  // mode latch, once after reset release
  // ----------------------------------------------------------------
  adcspi_mode_t mode_reg;
  logic [1:0]   latch_cnt_reg;
  logic         mode_ok_reg;

  wire latch_now = !mode_ok_reg && (latch_cnt_reg == 2'(MODE_LATCH_WAIT - 1));
  wire adcspi_mode_t pin_mode = pin_high_s ? AM_ASYNC : (!pin_low_s ? AM_MASTER : AM_SLAVE);

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      mode_reg      <= AM_ASYNC;
      latch_cnt_reg <= 2'h0;
      mode_ok_reg   <= 1'b0;
    end else if (!mode_ok_reg) begin
      latch_cnt_reg <= latch_cnt_reg + 2'h1;
      if (latch_now) begin
        mode_reg    <= pin_mode; // R23
        mode_ok_reg <= 1'b1;
      end
    end
  end

  wire is_async  = mode_ok_reg && (mode_reg == AM_ASYNC);
  wire is_master = mode_ok_reg && (mode_reg == AM_MASTER);
  wire is_slave  = mode_ok_reg && (mode_reg == AM_SLAVE);

  // ----------------------------------------------------------------
  // shift engines
  // ----------------------------------------------------------------
  adcspi_frame_if #(.FB(FB), .WB(WORD_BITS)) link_if ();
  adcspi_frame_if #(.FB(FB), .WB(WORD_BITS)) mst_if ();

  logic [FB-1:0] shadow_reg;
  logic          start_reg;
  logic          link_off_reg;
  logic          link_dout;
  logic          link_oe;
  logic          mst_dout;
  logic          mst_oe;
  logic          mst_sclk;

  // select high, or a mode without a host clock, holds the link in reset
  wire frame_rst = CS_N_IN || link_off_reg; // R1 R2 R22

  assign link_if.tx_word = shadow_reg;
  assign link_if.start   = 1'b0;
  assign mst_if.tx_word  = shadow_reg;
  assign mst_if.start    = start_reg;
  assign link_act_raw    = link_if.active;
  assign link_tgl_raw    = link_if.done_tgl;

  adcspi_link #(.FB(FB), .WB(WORD_BITS)) u_link (
    .sclk_in      (SCLK_IN),
    .rst_in       (RST_IN),
    .frame_rst_in (frame_rst),
    .din_in       (DIN_IN),
    .dout_out     (link_dout),
    .dout_oe_out  (link_oe),
    .frm          (link_if.eng)
  );

  adcspi_master #(.FB(FB), .WB(WORD_BITS), .HALF(INTERNAL_CLOCK_HALF)) u_master (
    .clk_in      (CLK_IN),
    .rst_in      (RST_IN || !is_master),
    .din_in      (din_s),
    .sclk_out    (mst_sclk),
    .dout_out    (mst_dout),
    .dout_oe_out (mst_oe),
    .frm         (mst_if.eng)
  );

  // mst_if.done_tgl is already on this clock; keep one stage for its edge
  logic mst_tgl_prev_reg;
  wire  mst_done   = mst_if.done_tgl ^ mst_tgl_prev_reg;
  wire  eng_active = is_master ? (mst_if.active || start_reg) : link_act_s;
  wire  eng_done   = is_master ? mst_done : link_done;
  wire [WORD_BITS-1:0] eng_word = is_master ? mst_if.rx_word : link_if.rx_word;

  // ----------------------------------------------------------------
  // result hand-off and overrun
  // ----------------------------------------------------------------
  logic unread_reg;
  wire  conv    = CONV_DONE_IN && mode_ok_reg;
  wire  overrun = conv && (unread_reg || eng_active);
  wire  load    = conv && !overrun;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      shadow_reg       <= '0;
      unread_reg       <= 1'b0;
      start_reg        <= 1'b0;
      link_off_reg     <= 1'b1;
      mst_tgl_prev_reg <= 1'b0;
    end else begin
      if (load) begin
        shadow_reg <= RESULT_IN; // R12
      end
      unread_reg       <= load || (unread_reg && !eng_done);
      start_reg        <= load && is_master; // R16
      link_off_reg     <= !(is_async || is_slave);
      mst_tgl_prev_reg <= mst_if.done_tgl;
    end
  end

  // ----------------------------------------------------------------
  // ready output in async mode
  // ----------------------------------------------------------------
  adcspi_rdy_t   rdy_reg;
  adcspi_rdy_t   rdy_next;
  logic [HW-1:0] pulse_cnt_reg;

  wire pulse_end = (pulse_cnt_reg == '0);

  always_comb begin
    rdy_next = rdy_reg;
    unique case (rdy_reg)
      RS_HIGH:  if (conv) rdy_next = RS_LOW; // R3
      RS_LOW: begin
        if (conv) begin
          rdy_next = RS_PULSE; // R11
        end else if (cs_rise) begin
          rdy_next = RS_HIGH; // R10
        end
      end
      RS_PULSE: if (pulse_end) rdy_next = RS_LOW;
      default:  rdy_next = RS_HIGH;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN || !is_async) begin
      rdy_reg       <= RS_HIGH;
      pulse_cnt_reg <= '0;
    end else begin
      rdy_reg <= rdy_next;
      if (rdy_reg == RS_LOW && conv) begin
        pulse_cnt_reg <= HW'(HALF_MOD - 1);
      end else if (!pulse_end) begin
        pulse_cnt_reg <= pulse_cnt_reg - HW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // slave mode: ready is an input checked against conversions
  // ----------------------------------------------------------------
  logic [SW-1:0] win_cnt_reg;
  wire           resync = is_slave && rdy_fall && (win_cnt_reg == '0) && !conv;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      win_cnt_reg <= '0;
    end else if (conv) begin
      win_cnt_reg <= SW'(SYNC_WIN);
    end else if (win_cnt_reg != '0) begin
      win_cnt_reg <= win_cnt_reg - SW'(1);
    end
  end

  // ----------------------------------------------------------------
  // flags and command hand-off; a set beats a same-cycle clear
  // ----------------------------------------------------------------
  logic                 missed_reg;
  logic                 resync_reg;
  logic                 filt_rst_reg;
  logic [WORD_BITS-1:0] cmd_reg;
  logic                 cmd_valid_reg;

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      missed_reg    <= 1'b0;
      resync_reg    <= 1'b0;
      filt_rst_reg  <= 1'b0;
      cmd_reg       <= '0;
      cmd_valid_reg <= 1'b0;
    end else begin
      missed_reg    <= overrun || (missed_reg && !FLAG_CLEAR_IN); // R12
      resync_reg    <= resync || (resync_reg && !FLAG_CLEAR_IN); // R25
      filt_rst_reg  <= resync;
      cmd_valid_reg <= eng_done; // R7
      if (eng_done) begin
        cmd_reg <= eng_word;
      end
    end
  end

  // ----------------------------------------------------------------
  // pins; polarity zero: idle clock low, phase one on both engines
  // ----------------------------------------------------------------
  wire rdy_async_n  = (rdy_reg != RS_LOW);
  wire rdy_master_n = !mst_if.active; // R16

  assign SCLK_OUT                  = is_master && mst_sclk; // R14 R24
  assign SCLK_OE_OUT               = is_master; // R20
  assign DOUT_OUT                  = is_master ? mst_dout : link_dout;
  assign DOUT_OE_OUT               = is_master ? mst_oe : (link_oe && !link_off_reg);
  assign CONVERSION_READY_N_OUT    = is_master ? rdy_master_n : rdy_async_n; // R17
  assign CONVERSION_READY_N_OE_OUT = !is_slave; // R13 R20
  assign FILTER_RESET_OUT          = filt_rst_reg;
  assign CMD_WORD_OUT              = cmd_reg;
  assign CMD_VALID_OUT             = cmd_valid_reg;
  assign MISSED_RESULT_FLAG_OUT    = missed_reg;
  assign RESYNC_EVENT_FLAG_OUT     = resync_reg;
  assign MODE_OUT                  = mode_ok_reg ? mode_reg : 3'h0;
endmodule
`default_nettype wire

// [tb/adcspi_chk.sv]
// checker on the serial interface top ports
`timescale 1ns/1ps
`default_nettype none
module adcspi_chk #(
  parameter int HALF_MOD = 2
) (
  // clock and inputs
  input wire logic       CLK_IN,
  input wire logic       RST_IN,
  input wire logic       CS_N_IN,
  input wire logic       CONV_DONE_IN,
  input wire logic       FLAG_CLEAR_IN,
  // outputs
  input wire logic       SCLK_OUT,
  input wire logic       SCLK_OE_OUT,
  input wire logic       DOUT_OE_OUT,
  input wire logic       CONVERSION_READY_N_OUT,
  input wire logic       CONVERSION_READY_N_OE_OUT,
  input wire logic       MISSED_RESULT_FLAG_OUT,
  input wire logic       RESYNC_EVENT_FLAG_OUT,
  input wire logic       FILTER_RESET_OUT,
  input wire logic [2:0] MODE_OUT
);
  wire logic am  = MODE_OUT == 3'b001;
  wire logic mm  = MODE_OUT == 3'b010;
  wire logic sm  = MODE_OUT == 3'b100;
  wire logic rdy = CONVERSION_READY_N_OUT;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  chk_ready_fall: assert property (am && CONV_DONE_IN && rdy |=> !rdy)
    else $error("ready stayed high");
  chk_ready_rise: assert property (am && $rose(CS_N_IN) && !rdy |-> ##[1:4] rdy)
    else $error("ready not released");
  chk_overrun_pulse: assert property (am && CONV_DONE_IN && !rdy |=> rdy ##HALF_MOD !rdy)
    else $error("bad overrun pulse");
  chk_missed_sticky: assert property (MISSED_RESULT_FLAG_OUT && !FLAG_CLEAR_IN |=> MISSED_RESULT_FLAG_OUT)
    else $error("missed flag lost");
  chk_ready_driven: assert property (!sm |-> CONVERSION_READY_N_OE_OUT)
    else $error("ready floated");
  chk_master_pins: assert property (mm |-> SCLK_OE_OUT && CONVERSION_READY_N_OE_OUT)
    else $error("master pins idle");
  chk_master_load: assert property (mm && CONV_DONE_IN && rdy |-> ##[2:3] !rdy)
    else $error("no frame start");
  chk_slave_pins: assert property (sm |-> !SCLK_OE_OUT && !SCLK_OUT && !CONVERSION_READY_N_OE_OUT)
    else $error("slave drives pins");
  chk_dout_float: assert property (!mm && CS_N_IN && $past(CS_N_IN) |-> !DOUT_OE_OUT)
    else $error("data out driven");
  chk_resync_pair: assert property (FILTER_RESET_OUT |-> RESYNC_EVENT_FLAG_OUT)
    else $error("reset without flag");
endmodule
bind adcspi_top adcspi_chk #(.HALF_MOD(HALF_MOD)) i_adcspi_chk (.*);
`default_nettype wire

// [tb/adcspi_host.sv]
// host model: clocks frames and captures read data
`timescale 1ns/1ps
`default_nettype none
module adcspi_host #(
  parameter int FB = 16
) (
  // driven by the host
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      din_out,
  // driven by the device
  input  wire logic dout_in,
  input  wire logic m_sclk_in,
  input  wire logic m_rdy_n_in
);
  logic [FB-1:0] m_rx;
  int            m_cnt = 0;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out  = 1'b0;
  end
  // 30 ns link period, offset so it never lines up with the system clock
  task automatic frame(input logic [FB-1:0] tx, input int nb, input bit grp, output logic [FB-1:0] rx);
    cs_n_out = 1'b0;
    #23;
    for (int i = 0; i < nb; i++) begin
      sclk_out = 1'b1;
      din_out  = tx[FB-1-i];
      #15;
      rx = {rx[FB-2:0], dout_in};
      sclk_out = 1'b0;
      #15;
      if (grp && i % 8 == 7) #97;
    end
    din_out = ~din_out;
  endtask
  task automatic done();
    #20 cs_n_out = 1'b1;
  endtask
  always @(posedge m_sclk_in) din_out <= ~din_out;
  // sample mid high phase: the bit stands there and the enable is still up
  always @(posedge m_sclk_in) begin
    if (!m_rdy_n_in && m_cnt < FB) begin
      #10;
      m_rx  = {m_rx[FB-2:0], dout_in};
      m_cnt = m_cnt + 1;
    end
  end
  always @(posedge m_rdy_n_in) m_cnt = 0;
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// bench for the converter serial interface
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int WB = 8;
  localparam int FB = 16;
  logic          clk = 1'b0, rst = 1'b1, cv = 1'b0, clr = 1'b0, m_hi = 1'b1, m_lo = 1'b0, rdy_n_drv = 1'b1;
  logic [FB-1:0] res = '0, rx, r, tx;
  logic [WB-1:0] last_cmd;
  wire logic     sclk, cs_n, din, sclk_o, dout, oe, rdy_n, rdy_oe, filt, cmd_v, missed, resync;
  wire logic     rdy_n_w = rdy_oe ? rdy_n : rdy_n_drv;
  // a floating data pin reads as the inverse, so a late sample shows up
  wire logic     dout_pin = oe ? dout : ~dout;
  wire logic [WB-1:0] cmd_w;
  wire logic [2:0]    mode;
  int            err_total, n_compared, n_cmd, n_filt, k;
  adcspi_top #(.WORD_BITS(WB), .FRAME_WORDS(2), .HALF_MOD(2)) i_adcspi_top (
    .CLK_IN(clk), .RST_IN(rst), .SCLK_IN(sclk), .SCLK_OUT(sclk_o), .SCLK_OE_OUT(), .CS_N_IN(cs_n),
    .DIN_IN(din), .DOUT_OUT(dout), .DOUT_OE_OUT(oe), .CONVERSION_READY_N_IN(rdy_n_w),
    .CONVERSION_READY_N_OUT(rdy_n), .CONVERSION_READY_N_OE_OUT(rdy_oe), .MODE_PIN_HIGH_IN(m_hi),
    .MODE_PIN_LOW_IN(m_lo), .CONV_DONE_IN(cv), .RESULT_IN(res), .FILTER_RESET_OUT(filt),
    .CMD_WORD_OUT(cmd_w), .CMD_VALID_OUT(cmd_v), .MISSED_RESULT_FLAG_OUT(missed),
    .RESYNC_EVENT_FLAG_OUT(resync), .FLAG_CLEAR_IN(clr), .MODE_OUT(mode));
  adcspi_host #(.FB(FB)) i_adcspi_host (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din), .dout_in(dout_pin),
    .m_sclk_in(sclk_o), .m_rdy_n_in(rdy_n_w));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // command pulse is one cycle wide and may land inside a host delay
  always @(posedge clk) begin
    if (cmd_v === 1'b1) begin
      n_cmd++;
      last_cmd <= cmd_w;
    end
    if (filt === 1'b1) n_filt++;
  end
  function automatic logic [WB-1:0] exp_cmd(input logic [FB-1:0] t);
    return t[FB-1 -: WB];
  endfunction
  task automatic cmp(input logic [FB-1:0] got, input logic [FB-1:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tmo();
    if (k >= 400) begin
      err_total++;
      summarize();
    end
  endtask
  task automatic restart(input logic hi, input logic lo);
    @(posedge clk);
    rst  <= 1'b1;
    m_hi <= hi;
    m_lo <= lo;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic conv(input logic [FB-1:0] v);
    @(posedge clk);
    res <= v;
    cv  <= 1'b1;
    @(posedge clk);
    cv <= 1'b0;
    #1;
  endtask
  task automatic rdy_wait();
    for (k = 0; k < 400 && rdy_n !== 1'b1; k++) @(posedge clk);
    tmo();
    #1;
  endtask
  initial begin
    void'($urandom(32'ha9439533));
    restart(1'b1, 1'b0);
    cmp(mode, 3'b001);
    for (int n = 0; n < 4; n++) begin
      r  = $urandom;
      tx = $urandom;
      conv(r);
      cmp(rdy_n, 1'b0);
      i_adcspi_host.frame(tx, FB, n[0], rx);
      cmp(rx, r);
      cmp(oe, 1'b0);
      cmp(rdy_n, 1'b0);
      i_adcspi_host.done();
      rdy_wait();
      cmp(last_cmd, exp_cmd(tx));
    end
    r = $urandom;
    conv(r);
    conv(~r);
    repeat (2) @(posedge clk);
    #1 cmp(missed, 1'b1);
    repeat (4) @(posedge clk);
    #1 cmp(rdy_n, 1'b0);
    k = n_cmd;
    i_adcspi_host.frame(~r, 5, 1'b0, rx);
    i_adcspi_host.done();
    cmp(n_cmd, k);
    rdy_wait();
    i_adcspi_host.frame(tx, FB, 1'b1, rx);
    cmp(rx, r);
    i_adcspi_host.done();
    rdy_wait();
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (2) @(posedge clk);
    #1 cmp(missed, 1'b0);
    restart(1'b0, 1'b0);
    cmp(mode, 3'b010);
    r = $urandom;
    conv(r);
    repeat (2) @(posedge clk);
    #1 cmp(rdy_n, 1'b0);
    rdy_wait();
    cmp(i_adcspi_host.m_rx, r);
    restart(1'b0, 1'b1);
    cmp(mode, 3'b100);
    repeat (12) @(posedge clk);
    rdy_n_drv <= 1'b0;
    for (k = 0; k < 400 && resync !== 1'b1; k++) @(posedge clk);
    tmo();
    #1 cmp(n_filt, 1);
    @(posedge clk);
    rdy_n_drv <= 1'b1;
    repeat (12) @(posedge clk);
    conv(r);
    @(posedge clk);
    rdy_n_drv <= 1'b0;
    repeat (12) @(posedge clk);
    #1 cmp(n_filt, 1);
    summarize();
  end
endmodule
`default_nettype wire
